// ===== hw/adc_control_status_registers.sv
`timescale 1ns/1ps

// Function
// [RQ1] Low result byte holds six result LSBs, top two bits zero.
// [RQ2] High result byte holds eight result MSBs of the selected channel.
// [RQ3] Done flag sets on conversion end, clears after both bytes read.
// [RQ4] Both result bytes come from one conversion until both read.
// [RQ5] Software leaves reference select and bypass bits at reset values.
// [RQ6] Half-rate bit runs the converter at half frequency.
// [RQ7] Readout select picks channel; codes five to seven read ground.
// [RQ8] Selected converter output routes onto both result bytes.
// [RQ9] Polarity bit swaps converter positive and negative inputs.
// [RQ10] Single mode clears enable after conversion; writing one restarts.
// [RQ11] Mode bit zero converts continuously, one converts once per enable.
// [RQ12] Scan bit cycles all channels, else named channel; resets to one.
// [RQ13] Buffer enable bit turns the converter input buffer on.
// [RQ14] Conversion channel field connects the converter input in single mode.
// [RQ15] Status shows references ready once internal references settle.
// [RQ16] Status shows input undervoltage while input below lockout.
// [RQ17] Status shows current-set pin low when that pin is shorted.
// [RQ18] Storage discharge sink stays on until software clears it.
// [RQ19] Forced health check runs one check, clears when it completes.
// [RQ20] Forced power-off drives the undervoltage reset state.
// [RQ21] Factory byte reads zero; software never writes it.
// [RQ22] Supply status reserved bits read zero.
module adc_control_status_registers
    import adc_regs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input adc_regs_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input adc_regs_pkg::conv_result_t conv_res,
    output adc_regs_pkg::conv_ctrl_t conv_ctrl,
    input wire logic references_ready_in,
    input wire logic input_undervoltage_in,
    input wire logic current_set_low_in,
    input wire logic bset_high_in,
    input wire logic health_check_done,
    output logic storage_discharge_sink,
    output logic forced_health_check,
    output logic forced_power_off
);

    // ****************************************
    // Declarations
    // ****************************************
    // Read data register
    logic [7:0] rdata_q;

    // Readout configuration fields
    logic vref_sel_q;
    logic vref_byp_q;
    logic half_q;
    logic [2:0] readout_channel_select_q;

    // Conversion configuration fields
    logic swap_q;
    logic en_q;
    logic en_d;
    logic single_q;
    logic scan_all_select_q;
    logic input_buffer_enable_q;
    logic [2:0] conversion_channel_select_q;
    logic start_q;
    logic single_done;

    // System control fields
    logic sink_q;
    logic hchk_q;
    logic hchk_d;
    logic pwroff_q;

    // Comparator synchroniser stages
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;

    // Address hits, one per mapped offset except the factory byte
    logic hit_high;
    logic hit_low;
    logic hit_readout;
    logic hit_conv;
    logic hit_status;
    logic hit_ctrl;

    // Access strobes
    logic wr_readout;
    logic wr_conv;
    logic wr_ctrl;
    logic rd_high;
    logic rd_low;

    // Result store outputs
    logic [7:0] result_high;
    logic [LOW_W-1:0] result_low;
    logic data_ready;

    // Read values per register
    logic [7:0] readout_val;
    logic [7:0] conv_val;
    logic [7:0] status_val;
    logic [7:0] ctrl_val;
    logic [7:0] low_val;
    logic [7:0] rd_mux;

    // ****************************************
    // Register access decode
    // ****************************************

    // Offset compares shared by strobes and the read mux
    assign hit_high = reg_req.addr == OFS_RESULT_HIGH;
    assign hit_low = reg_req.addr == OFS_RESULT_LOW;
    assign hit_readout = reg_req.addr == OFS_READOUT_CFG;
    assign hit_conv = reg_req.addr == OFS_CONV_CFG;
    assign hit_status = reg_req.addr == OFS_SUPPLY_STATUS;
    assign hit_ctrl = reg_req.addr == OFS_SYSTEM_CTRL;

    // Write strobes; read-only and unmapped offsets take no write
    assign wr_readout = reg_req.wr && hit_readout;
    assign wr_conv = reg_req.wr && hit_conv;
    assign wr_ctrl = reg_req.wr && hit_ctrl;

    // Read strobes that consume the result pair
    assign rd_high = reg_req.rd && hit_high;
    assign rd_low = reg_req.rd && hit_low;

    // ****************************************
    // Result capture
    // ****************************************

    // Keeps the byte pair coherent across reads
    // A read of either byte freezes the pair until the other
    adc_result_store u_store (
        .clk(clk),
        .rst(rst),
        .conv_res(conv_res),
        .sel(readout_channel_select_q), // RQ7
        .rd_high(rd_high),
        .rd_low(rd_low),
        .result_high(result_high),
        .result_low(result_low),
        .data_ready(data_ready)
    );

    // ****************************************
    // Readout configuration
    // ****************************************

    // Reference bits are writable but software keeps them at reset
    always_ff @(posedge clk) begin
        if (rst) begin
            vref_sel_q <= RST_READOUT_CFG[RD_VREF_SEL];
            vref_byp_q <= RST_READOUT_CFG[RD_VREF_BYP];
        end else if (wr_readout) begin
            vref_sel_q <= reg_req.wdata[RD_VREF_SEL]; // RQ5
            vref_byp_q <= reg_req.wdata[RD_VREF_BYP]; // RQ5
        end
    end

    // Clock rate and readout select
    always_ff @(posedge clk) begin
        if (rst) begin
            half_q <= RST_READOUT_CFG[RD_HALF];
            readout_channel_select_q <= RST_READOUT_CFG[2:0];
        end else if (wr_readout) begin
            half_q <= reg_req.wdata[RD_HALF]; // RQ6
            readout_channel_select_q <= reg_req.wdata[2:0]; // RQ7
        end
    end

    // ****************************************
    // Conversion configuration
    // ****************************************

    // A single-mode conversion retires the enable
    assign single_done = single_q && conv_res.done; // RQ10

    // Software write wins over the automatic clear
    assign en_d = wr_conv ? reg_req.wdata[CV_EN]
                : single_done ? 1'b0 // RQ10 RQ11
                : en_q;

    // Mode fields follow software writes
    always_ff @(posedge clk) begin
        if (rst) begin
            single_q <= RST_CONV_CFG[CV_SINGLE];
            scan_all_select_q <= RST_CONV_CFG[CV_SCAN];
        end else if (wr_conv) begin
            single_q <= reg_req.wdata[CV_SINGLE]; // RQ11
            scan_all_select_q <= reg_req.wdata[CV_SCAN]; // RQ12
        end
    end

    // Input path fields follow software writes
    always_ff @(posedge clk) begin
        if (rst) begin
            swap_q <= RST_CONV_CFG[CV_SWAP];
            input_buffer_enable_q <= RST_CONV_CFG[CV_BUF];
            conversion_channel_select_q <= RST_CONV_CFG[2:0];
        end else if (wr_conv) begin
            swap_q <= reg_req.wdata[CV_SWAP]; // RQ9
            input_buffer_enable_q <= reg_req.wdata[CV_BUF]; // RQ13
            conversion_channel_select_q <= reg_req.wdata[2:0]; // RQ14
        end
    end

    // Enable follows its next-state logic
    always_ff @(posedge clk) begin
        if (rst) begin
            en_q <= RST_CONV_CFG[CV_EN];
        end else begin
            en_q <= en_d; // RQ10 RQ11
        end
    end

    // One-cycle start on each write of one, even if already enabled
    always_ff @(posedge clk) begin
        if (rst) begin
            start_q <= 1'b0;
        end else begin
            start_q <= wr_conv && reg_req.wdata[CV_EN]; // RQ10
        end
    end

    // ****************************************
    // Converter control outputs
    // ****************************************

    // All fields straight from flops, no decode glitches
    assign conv_ctrl.enable = en_q; // RQ11
    assign conv_ctrl.start = start_q; // RQ10
    assign conv_ctrl.single = single_q; // RQ11
    assign conv_ctrl.scan = scan_all_select_q; // RQ12

    // Analog front-end settings, passed straight through
    assign conv_ctrl.half_rate = half_q; // RQ6
    assign conv_ctrl.swap = swap_q; // RQ9
    assign conv_ctrl.buffer_en = input_buffer_enable_q; // RQ13
    assign conv_ctrl.vref_sel = vref_sel_q;
    assign conv_ctrl.vref_bypass = vref_byp_q;
    assign conv_ctrl.channel = conversion_channel_select_q; // RQ14

    // ****************************************
    // Analog status synchronisers
    // ****************************************

    // Comparator levels are asynchronous; two flops before use
    // Status reads zero until both stages have filled after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= {references_ready_in, bset_high_in,
                           input_undervoltage_in, current_set_low_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    // ****************************************
    // System control
    // ****************************************

    // Health check set by a write wins over its completion
    // A write of zero withdraws a request that has not finished
    assign hchk_d = (wr_ctrl && reg_req.wdata[CT_HCHK]) ? 1'b1
                  : health_check_done ? 1'b0 // RQ19
                  : wr_ctrl ? 1'b0
                  : hchk_q;

    // Sink current stays on until software writes a zero
    always_ff @(posedge clk) begin
        if (rst) begin
            sink_q <= RST_SYSTEM_CTRL[CT_SINK];
        end else if (wr_ctrl) begin
            sink_q <= reg_req.wdata[CT_SINK]; // RQ18
        end
    end

    // Health check request until the check reports completion
    always_ff @(posedge clk) begin
        if (rst) begin
            hchk_q <= RST_SYSTEM_CTRL[CT_HCHK];
        end else begin
            hchk_q <= hchk_d; // RQ19
        end
    end

    // Power-off is a plain level held until rewritten
    always_ff @(posedge clk) begin
        if (rst) begin
            pwroff_q <= RST_SYSTEM_CTRL[CT_PWROFF];
        end else if (wr_ctrl) begin
            pwroff_q <= reg_req.wdata[CT_PWROFF]; // RQ20
        end
    end

    assign storage_discharge_sink = sink_q; // RQ18
    assign forced_health_check = hchk_q; // RQ19
    assign forced_power_off = pwroff_q; // RQ20

    // ****************************************
    // Read values
    // ****************************************

    // Low byte: upper two bits tie to zero
    assign low_val = {2'b00, result_low}; // RQ1

    // Readout config: bit 3 reserved, reads zero
    assign readout_val = {data_ready, vref_sel_q, vref_byp_q, half_q,
                          1'b0, readout_channel_select_q};

    // Conversion config: all bits readable
    assign conv_val = {swap_q, en_q, single_q, scan_all_select_q,
                       input_buffer_enable_q, conversion_channel_select_q};

    // Supply status: reserved 6, 5, 3, 2 forced low
    assign status_val = {pin_sync_q[3], 2'b00, pin_sync_q[2], // RQ15 RQ22
                         2'b00, pin_sync_q[1], pin_sync_q[0]}; // RQ16 RQ17

    // System control: reserved upper bits read zero
    assign ctrl_val = {5'b0_0000, sink_q, hchk_q, pwroff_q};

    // Unmapped offsets and the factory byte read zero
    assign rd_mux = hit_high ? result_high // RQ2
                  : hit_low ? low_val
                  : hit_readout ? readout_val
                  : hit_conv ? conv_val
                  : hit_status ? status_val
                  : hit_ctrl ? ctrl_val
                  : FACTORY_VALUE; // RQ21

    // ****************************************
    // Read data register
    // ****************************************

    // Data holds until the next read, so a slow bus engine
    // may collect it late; writes never disturb it
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (reg_req.rd) begin
            rdata_q <= rd_mux;
        end
    end

    assign reg_rdata = rdata_q;

endmodule // adc_control_status_registers

// ===== hw/adc_regs_pkg.sv
package adc_regs_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h05;
    localparam logic [7:0] OFS_RESULT_LOW = 8'h06;
    localparam logic [7:0] OFS_READOUT_CFG = 8'h07;
    localparam logic [7:0] OFS_CONV_CFG = 8'h08;
    localparam logic [7:0] OFS_SUPPLY_STATUS = 8'h09;
    localparam logic [7:0] OFS_SYSTEM_CTRL = 8'h0a;
    localparam logic [7:0] OFS_FACTORY = 8'h0b;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_READOUT_CFG = 8'h00;
    localparam logic [7:0] RST_CONV_CFG = 8'h10;
    localparam logic [7:0] RST_SYSTEM_CTRL = 8'h00;
    localparam logic [7:0] FACTORY_VALUE = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int RD_READY = 7;
    localparam int RD_VREF_SEL = 6;
    localparam int RD_VREF_BYP = 5;
    localparam int RD_HALF = 4;
    localparam int CV_SWAP = 7;
    localparam int CV_EN = 6;
    localparam int CV_SINGLE = 5;
    localparam int CV_SCAN = 4;
    localparam int CV_BUF = 3;
    localparam int ST_REF = 7;
    localparam int ST_BSET = 4;
    localparam int ST_UV = 1;
    localparam int ST_CURRENT_SET_PIN = 0;
    localparam int CT_SINK = 2;
    localparam int CT_HCHK = 1;
    localparam int CT_PWROFF = 0;

    // ****************************************
    // Result layout
    // ****************************************
    localparam int RESULT_W = 14;
    localparam int LOW_W = 6;
    localparam int NUM_SLOTS = 6;

    // Channel codes; 5 to 7 all mean analog ground
    typedef enum logic [2:0] {
        CH_CURRENT = 3'h0,
        CH_INPUT_VOLTAGE = 3'h1,
        CH_STORAGE_RAIL = 3'h2,
        CH_OUTPUT_VOLTAGE = 3'h3,
        CH_TEMPERATURE = 3'h4,
        CH_ANALOG_GROUND = 3'h5
    } chan_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic done;
        logic [2:0] channel;
        logic [RESULT_W-1:0] data;
    } conv_result_t;

    typedef struct packed {
        logic enable;
        logic start;
        logic single;
        logic scan;
        logic half_rate;
        logic swap;
        logic buffer_en;
        logic vref_sel;
        logic vref_bypass;
        logic [2:0] channel;
    } conv_ctrl_t;

endpackage

// ===== hw/adc_result_store.sv
`timescale 1ns/1ps
module adc_result_store
    import adc_regs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input adc_regs_pkg::conv_result_t conv_res,
    input wire logic [2:0] sel,
    input wire logic rd_high,
    input wire logic rd_low,
    output logic [7:0] result_high,
    output logic [LOW_W-1:0] result_low,
    output logic data_ready
);
    logic [RESULT_W-1:0] slot_q [NUM_SLOTS];
    logic [RESULT_W-1:0] snap_q;
    logic [1:0] seen_q;
    logic [1:0] seen_d;
    logic ready_q;
    logic [2:0] sel_slot;
    logic [2:0] res_slot;
    logic consumed;
    logic hold;

    // Ground codes share one slot
    assign sel_slot = (sel > CH_TEMPERATURE) ? CH_ANALOG_GROUND : sel;
    assign res_slot = (conv_res.channel > CH_TEMPERATURE) ? CH_ANALOG_GROUND
                                                          : conv_res.channel;
    assign seen_d = seen_q | {rd_high, rd_low};
    assign consumed = &seen_d;
    assign hold = |seen_q;

    // Latest result per channel
    for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
        always_ff @(posedge clk) begin
            if (rst) begin
                slot_q[i] <= '0;
            end else if (conv_res.done && res_slot == 3'(i)) begin
                slot_q[i] <= conv_res.data;
            end
        end
    end

    // Pair frozen after the first byte read, so halves never mix
    always_ff @(posedge clk) begin
        if (rst) begin
            snap_q <= '0;
            seen_q <= '0;
        end else begin
            if ((!hold && !rd_high && !rd_low) || consumed) snap_q <= slot_q[sel_slot]; // RQ4 RQ8
            seen_q <= consumed ? 2'b00 : seen_d;
        end
    end

    // Set wins over the clear by the second read
    always_ff @(posedge clk) begin
        if (rst) begin
            ready_q <= 1'b0;
        end else if (conv_res.done && res_slot == sel_slot) begin
            ready_q <= 1'b1; // RQ3
        end else if (consumed) begin
            ready_q <= 1'b0; // RQ3
        end
    end

    assign result_high = snap_q[RESULT_W-1:LOW_W]; // RQ2
    assign result_low = snap_q[LOW_W-1:0]; // RQ1
    assign data_ready = ready_q;

endmodule // adc_result_store

// ===== verification/adc_control_status_registers_test.sv
`timescale 1ns/1ps
module adc_control_status_registers_test;
    import adc_regs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    conv_result_t conv_res;
    conv_ctrl_t conv_ctrl;
    logic [3:0] stat_in = 4'h0;
    logic [13:0] next_data = 14'h0;
    logic [13:0] old_data;
    logic health_check_done, storage_discharge_sink, forced_health_check, forced_power_off;
    logic [7:0] exp_q[$];
    logic [7:0] rst_val[7] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
    logic rd_seen = 1'b0;
    logic [31:0] seed = 32'hb0fe_7f99;
    logic [7:0] w;
    int n_errors = 0;
    int comparisons = 0;

    always #2 clk = ~clk;

    adc_control_status_registers adc_control_status_registers_i (.clk(clk), .rst(rst),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .conv_res(conv_res), .conv_ctrl(conv_ctrl),
        .references_ready_in(stat_in[3]), .bset_high_in(stat_in[2]),
        .input_undervoltage_in(stat_in[1]), .current_set_low_in(stat_in[0]),
        .health_check_done(health_check_done), .storage_discharge_sink(storage_discharge_sink),
        .forced_health_check(forced_health_check), .forced_power_off(forced_power_off));
    adc_converter_model adc_converter_model_i (.clk(clk), .rst(rst), .conv_ctrl(conv_ctrl),
        .next_data(next_data), .forced_health_check(forced_health_check),
        .conv_res(conv_res), .health_check_done(health_check_done));

    // ****************************************
    // Bus tasks and checking
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        reg_req.wr <= 1'b0;
        @(negedge clk);
    endtask
    // Idle cycle after each read keeps read data unambiguous
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        exp_q.push_back(exp);
        @(negedge clk);
        reg_req.rd <= 1'b0;
        @(negedge clk);
    endtask
    task automatic wait_done();
        for (int i = 0; i < 50 && conv_res.done !== 1'b1; i++) @(negedge clk);
        check("done seen", {7'h0, conv_res.done}, 8'h01);
        repeat (4) @(negedge clk);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Read data settles one idle cycle after the strobe
    always @(negedge clk) begin
        rd_seen <= reg_req.rd;
        if (rd_seen && exp_q.size() > 0) check("rdata", reg_rdata, exp_q.pop_front());
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst <= 1'b0;
        check("scan", conv_ctrl.scan, 8'h01);
        // Both result bytes read, so no half-read pair is left frozen
        foreach (rst_val[i]) rd(OFS_RESULT_HIGH + 8'(i), rst_val[i]);
        $display("test reset finished");
        repeat (4) begin
            w = 8'(rnd());
            wr(OFS_READOUT_CFG, w & 8'h1f);
            rd(OFS_READOUT_CFG, w & 8'h17);
            check("half", conv_ctrl.half_rate, w[4]);
            w = 8'(rnd()) & 8'hbf;
            wr(OFS_CONV_CFG, w);
            rd(OFS_CONV_CFG, w);
            check("cfg", {conv_ctrl.swap, conv_ctrl.single, conv_ctrl.scan, conv_ctrl.buffer_en,
                conv_ctrl.channel}, {w[7], w[5:0]});
        end
        $display("test config finished");
        for (int ch = 0; ch < 8; ch++) begin
            w = 8'(ch);
            next_data = 14'(rnd());
            wr(OFS_READOUT_CFG, w);
            wr(OFS_CONV_CFG, 8'h60 | w);
            wait_done();
            check("enable", conv_ctrl.enable, 8'h00);
            rd(OFS_READOUT_CFG, 8'h80 | w);
            rd(OFS_RESULT_HIGH, next_data[13:6]);
            old_data = next_data;
            // A new result between the two reads must not split the pair
            if (ch == 7) begin
                next_data = ~old_data;
                wr(OFS_CONV_CFG, 8'h60 | w);
                wait_done();
            end
            rd(OFS_RESULT_LOW, {2'h0, old_data[5:0]});
            if (ch < 7) rd(OFS_READOUT_CFG, w);
        end
        wr(OFS_CONV_CFG, 8'h41);
        wait_done();
        wait_done();
        check("enable", conv_ctrl.enable, 8'h01);
        wr(OFS_CONV_CFG, 8'h10);
        $display("test conversion finished");
        repeat (4) begin
            stat_in <= 4'(rnd());
            repeat (5) @(negedge clk);
            rd(OFS_SUPPLY_STATUS, {stat_in[3], 2'h0, stat_in[2], 2'h0, stat_in[1:0]});
        end
        $display("test status finished");
        wr(OFS_SYSTEM_CTRL, 8'h07);
        check("ctrl", {storage_discharge_sink, forced_health_check, forced_power_off}, 8'h07);
        for (int i = 0; i < 20 && forced_health_check === 1'b1; i++) @(negedge clk);
        check("hchk", forced_health_check, 8'h00);
        rd(OFS_SYSTEM_CTRL, 8'h05);
        wr(OFS_SYSTEM_CTRL, 8'h00);
        check("sink", storage_discharge_sink, 8'h00);
        $display("test control finished");
        wr(8'h20, 8'hff);
        wr(OFS_SUPPLY_STATUS, 8'hff);
        rd(OFS_FACTORY, 8'h00);
        rd(OFS_SUPPLY_STATUS, {stat_in[3], 2'h0, stat_in[2], 2'h0, stat_in[1:0]});
        rd(8'h20, 8'h00);
        $display("test refusal finished");
        repeat (3) @(negedge clk);
        give_verdict();
    end
    // Run needs under 1000 cycles; this cuts a hang
    initial begin
        #20000;
        n_errors++;
        give_verdict();
    end
endmodule // adc_control_status_registers_test

// ===== verification/adc_converter_model.sv
`timescale 1ns/1ps
module adc_converter_model (
    input wire logic clk,
    input wire logic rst,
    input adc_regs_pkg::conv_ctrl_t conv_ctrl,
    input wire logic [13:0] next_data,
    input wire logic forced_health_check,
    output adc_regs_pkg::conv_result_t conv_res,
    output logic health_check_done
);
    import adc_regs_pkg::*;
    // ****************************************
    // Converter and health check stand-in
    // ****************************************
    logic busy_q;
    logic [2:0] cnt_q;
    logic [3:0] hc_q;
    wire logic fire = busy_q && cnt_q == 3'h3;
    // Idle data is inverted so a stale value never passes for a result
    assign conv_res = {fire, conv_ctrl.channel, fire ? next_data : ~next_data};
    // Conversion timer; continuous mode rearms after each result
    always_ff @(posedge clk) begin
        if (rst || fire) begin
            busy_q <= 1'b0;
            cnt_q <= 3'h0;
        end else if (conv_ctrl.start || (conv_ctrl.enable && !conv_ctrl.single) || busy_q) begin
            busy_q <= 1'b1;
            cnt_q <= cnt_q + 3'h1;
        end
    end
    // Check ends a fixed time after it is forced
    always_ff @(posedge clk) begin
        if (rst || !forced_health_check) hc_q <= 4'h0;
        else if (hc_q != 4'h8) hc_q <= hc_q + 4'h1;
    end
    assign health_check_done = hc_q == 4'h7;
endmodule // adc_converter_model

// ===== verification/adc_csr_properties.sv
`timescale 1ns/1ps
module adc_csr_checker (
    input wire logic clk,
    input wire logic rst,
    input adc_regs_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input adc_regs_pkg::conv_result_t conv_res,
    input adc_regs_pkg::conv_ctrl_t conv_ctrl,
    input wire logic health_check_done,
    input wire logic storage_discharge_sink,
    input wire logic forced_health_check,
    input wire logic forced_power_off
);
    import adc_regs_pkg::*;
    // ****************************************
    // Register port properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Write strobes that may override the automatic updates
    wire logic conv_wr = reg_req.wr && reg_req.addr == OFS_CONV_CFG;
    wire logic ctl_wr = reg_req.wr && reg_req.addr == OFS_SYSTEM_CTRL;
    sequence wr_at(a);
        reg_req.wr && reg_req.addr == a;
    endsequence
    // Idle cycle after the read, so read data cannot be a newer read's
    sequence rd_of(a);
        reg_req.rd && reg_req.addr == a ##1 !reg_req.rd;
    endsequence
    AST_START: assert property (wr_at(OFS_CONV_CFG) ##0 reg_req.wdata[CV_EN] && !conv_ctrl.enable
        |=> conv_ctrl.start ##1 !conv_ctrl.start) else $error("no start pulse");
    AST_FIELDS: assert property (wr_at(OFS_CONV_CFG) |=> conv_ctrl.swap == $past(reg_req.wdata[7])
        && conv_ctrl.channel == $past(reg_req.wdata[2:0])) else $error("conv fields wrong");
    AST_HALF: assert property (wr_at(OFS_READOUT_CFG)
        |=> conv_ctrl.half_rate == $past(reg_req.wdata[RD_HALF])) else $error("half rate wrong");
    AST_ONE_SHOT: assert property (conv_res.done && conv_ctrl.single && !conv_wr
        |=> !conv_ctrl.enable) else $error("enable kept after single conversion");
    AST_CONTINUOUS: assert property (conv_res.done && conv_ctrl.enable && !conv_ctrl.single
        && !conv_wr |=> conv_ctrl.enable) else $error("continuous enable dropped");
    AST_LOW_TOP: assert property (rd_of(OFS_RESULT_LOW) |=> reg_rdata[7:6] == 2'h0)
        else $error("low byte top bits set");
    AST_STATUS_RSV: assert property (rd_of(OFS_SUPPLY_STATUS)
        |=> reg_rdata[6:5] == 2'h0 && reg_rdata[3:2] == 2'h0) else $error("status reserved set");
    AST_FACTORY: assert property (rd_of(OFS_FACTORY) |=> reg_rdata == FACTORY_VALUE)
        else $error("factory byte not zero");
    AST_HCHK: assert property (ctl_wr && reg_req.wdata[CT_HCHK] |=> forced_health_check)
        else $error("health check not forced");
    AST_HCHK_END: assert property (health_check_done && !ctl_wr |=> !forced_health_check)
        else $error("health check not cleared");
    AST_SINK: assert property (storage_discharge_sink && !ctl_wr |=> storage_discharge_sink)
        else $error("sink dropped");
    AST_PWROFF: assert property (ctl_wr |=> forced_power_off == $past(reg_req.wdata[CT_PWROFF]))
        else $error("power off wrong");
endmodule // adc_csr_checker

bind adc_control_status_registers adc_csr_checker adc_csr_checker_i (.clk(clk), .rst(rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .conv_res(conv_res), .conv_ctrl(conv_ctrl),
    .health_check_done(health_check_done), .storage_discharge_sink(storage_discharge_sink),
    .forced_health_check(forced_health_check), .forced_power_off(forced_power_off));
